// ### hw/clkgen_regs.sv
// Purpose: Software-visible clock generator control registers and control outputs
// Assumes: Single system clock, asynchronous active-high reset
// Notes:   Analogue PLL is outside; ratios and enables drive it as ports
//          Mode and rate selects are levels from logic on this same clock
//          Memory clock on/off switching is not glitch-free; reset its user after
`timescale 1ns/1ps
module clkgen_regs
   import clkgen_regs_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   input  wire io_req_t     IO_REQ,
   output logic      [15:0] IO_RDATA,
   input  wire logic        PLL_MODE_REQ,
   input  wire logic        HALF_RATE,
   output logic             PLL_MODE,
   output logic             PLL_POWER_DOWN,
   output logic             PLL_NORMAL_OP,
   output logic      [12:0] PLL_MULTIPLIER,
   output logic             REF_DIVIDER_BYPASS,
   output logic      [12:0] REF_DIVIDE_VALUE,
   output logic      [15:0] PLL_TEST_WORD,
   output logic             OUTPUT_DIVIDER_ENABLE,
   output logic      [8:0]  OUTPUT_DIVIDE_VALUE,
   output logic             MEMORY_CLOCK_PIN
);

   // ==========================================================
   // Register storage
   logic [15:0] pll_power_feedback_ctrl;
   logic [15:0] reference_divider_ctrl;
   logic [15:0] pll_test_init_word;
   logic [15:0] output_divider_ctrl;
   logic [15:0] memory_clock_output_ctrl;
   clk_mode_t   mode;
   logic        mem_clk;
   logic        half_phase;

   // Address decode
   wire sel_pwr    = IO_REQ.wr && (IO_REQ.addr == PWR_FB_CTRL_ADDR);
   wire sel_refdiv = IO_REQ.wr && (IO_REQ.addr == REFDIV_CTRL_ADDR);
   wire sel_test   = IO_REQ.wr && (IO_REQ.addr == TEST_INIT_ADDR);
   wire sel_outdiv = IO_REQ.wr && (IO_REQ.addr == OUTDIV_CTRL_ADDR);
   wire sel_memclk = IO_REQ.wr && (IO_REQ.addr == MEMCLK_CTRL_ADDR);

   // PLL mode entry is refused while the PLL is powered down
   wire pwrdn        = pll_power_feedback_ctrl[PWRDN_BIT];
   wire memclk_en    = memory_clock_output_ctrl[MEMCLK_EN_BIT];
   wire enter_ok     = PLL_MODE_REQ && !pwrdn;
   // Hazard: only entry is guarded; software must not power down in PLL mode
   clk_mode_t next_mode;
   assign next_mode  = !PLL_MODE_REQ ? MODE_BYPASS :
                       (mode == MODE_PLL || enter_ok) ? MODE_PLL : MODE_BYPASS;

   // Register writes, reserved bits masked away
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pll_power_feedback_ctrl  <= PWR_FB_RESET;
         reference_divider_ctrl   <= REFDIV_RESET;
         pll_test_init_word       <= TEST_INIT_RESET;
         output_divider_ctrl      <= OUTDIV_RESET;
         memory_clock_output_ctrl <= MEMCLK_RESET;
      end else begin
         if (sel_pwr)
            pll_power_feedback_ctrl <= masked_write(PWR_FB_MASK, IO_REQ.wdata);
         if (sel_refdiv)
            reference_divider_ctrl <= masked_write(REFDIV_MASK, IO_REQ.wdata);
         if (sel_test)
            pll_test_init_word <= IO_REQ.wdata;
         if (sel_outdiv)
            output_divider_ctrl <= masked_write(OUTDIV_MASK, IO_REQ.wdata);
         if (sel_memclk)
            memory_clock_output_ctrl <= masked_write(MEMCLK_MASK, IO_REQ.wdata);
      end
   end

   // Clock source mode; power-down after entry is not guarded
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET)
         mode <= MODE_BYPASS;
      else
         mode <= next_mode;
   end

   // Memory clock: full rate toggles each cycle, half rate every second
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         mem_clk    <= 1'b0;
         half_phase <= 1'b0;
      end else if (!memclk_en) begin
         mem_clk    <= 1'b0;
         half_phase <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
         if (!HALF_RATE || half_phase)
            mem_clk <= ~mem_clk;
      end
   end

   // Read data mux; unmapped addresses read zero
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET)
         IO_RDATA <= 16'h0000;
      else if (IO_REQ.rd) begin
         unique case (IO_REQ.addr)
            PWR_FB_CTRL_ADDR: IO_RDATA <= pll_power_feedback_ctrl;
            REFDIV_CTRL_ADDR: IO_RDATA <= reference_divider_ctrl;
            TEST_INIT_ADDR:   IO_RDATA <= pll_test_init_word;
            OUTDIV_CTRL_ADDR: IO_RDATA <= output_divider_ctrl;
            MEMCLK_CTRL_ADDR: IO_RDATA <= memory_clock_output_ctrl;
            default:          IO_RDATA <= 16'h0000;
         endcase
      end
   end

   // Control outputs to the analogue PLL and dividers
   assign PLL_MODE              = (mode == MODE_PLL);
   assign PLL_POWER_DOWN        = pwrdn;
   assign PLL_NORMAL_OP         = pll_power_feedback_ctrl[NORMAL_OP_BIT];
   assign PLL_MULTIPLIER        = {1'b0, pll_power_feedback_ctrl[RATIO12_W-1:0]}
                                  + MULT_OFFSET;
   assign REF_DIVIDER_BYPASS    = reference_divider_ctrl[REFBYP_BIT];
   assign REF_DIVIDE_VALUE      = {1'b0, reference_divider_ctrl[RATIO12_W-1:0]}
                                  + REFDIV_OFFSET;
   assign PLL_TEST_WORD         = pll_test_init_word;
   assign OUTPUT_DIVIDER_ENABLE = output_divider_ctrl[OUTDIV_EN_BIT];
   assign OUTPUT_DIVIDE_VALUE   = {1'b0, output_divider_ctrl[OUTPUT_DIVIDER_RATIO_W-1:0]}
                                  + ODIV_OFFSET;
   assign MEMORY_CLOCK_PIN      = mem_clk;

   // ==========================================================
   // Assertions
   // Mode entry is refused while powered down, taken once power is up
   pwrdn_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (mode == MODE_BYPASS && pwrdn) |=> mode == MODE_BYPASS)
      else $error("PLL mode entered while powered down");
   pll_enter_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (PLL_MODE_REQ && !pwrdn) |=> PLL_MODE)
      else $error("PLL mode not entered");

   // Dropping the request returns to bypass; power-down after entry is not guarded
   mode_exit_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !PLL_MODE_REQ |=> !PLL_MODE)
      else $error("PLL mode kept without request");
   mode_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (PLL_MODE && PLL_MODE_REQ) |=> PLL_MODE)
      else $error("PLL mode dropped while requested");

   // Memory clock: low when off, toggling at full or half rate when on
   memclk_off_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !memclk_en |=> !MEMORY_CLOCK_PIN)
      else $error("Memory clock not low when disabled");
   memclk_full_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (memclk_en && !HALF_RATE) ##1 (memclk_en && !HALF_RATE)
      |-> MEMORY_CLOCK_PIN != $past(MEMORY_CLOCK_PIN))
      else $error("Memory clock not toggling at full rate");
   memclk_half_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (memclk_en && HALF_RATE) [*3]
      |-> (MEMORY_CLOCK_PIN != $past(MEMORY_CLOCK_PIN))
          != ($past(MEMORY_CLOCK_PIN) != $past(MEMORY_CLOCK_PIN, 2)))
      else $error("Memory clock not toggling at half rate");
   memclk_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      sel_memclk |=> memclk_en == $past(IO_REQ.wdata[MEMCLK_EN_BIT]))
      else $error("Memory clock enable not written");

   // Written values reach the outputs one cycle after the strobe
   mult_value_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      sel_pwr |=> PLL_MULTIPLIER == {1'b0, $past(IO_REQ.wdata[11:0])} + 13'h0004)
      else $error("Multiplier wrong");
   pwrdn_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      sel_pwr |=> PLL_POWER_DOWN == $past(IO_REQ.wdata[12]))
      else $error("Power-down bit not written");
   refdiv_value_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      sel_refdiv |=> REF_DIVIDE_VALUE == {1'b0, $past(IO_REQ.wdata[11:0])} + 13'h0004
      && REF_DIVIDER_BYPASS == $past(IO_REQ.wdata[15]))
      else $error("Reference divider wrong");
   outdiv_value_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      sel_outdiv |=> OUTPUT_DIVIDE_VALUE == {1'b0, $past(IO_REQ.wdata[7:0])} + 9'h001
      && OUTPUT_DIVIDER_ENABLE == $past(IO_REQ.wdata[9]))
      else $error("Output divider wrong");

   // Registers change only under their own write strobe
   pwr_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !sel_pwr |=> $stable(pll_power_feedback_ctrl))
      else $error("Power and feedback register changed without write");
   refdiv_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !sel_refdiv |=> $stable(reference_divider_ctrl))
      else $error("Reference divider register changed without write");
   outdiv_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !sel_outdiv |=> $stable(output_divider_ctrl))
      else $error("Output divider register changed without write");
   memclk_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !sel_memclk |=> $stable(memory_clock_output_ctrl))
      else $error("Memory clock register changed without write");

   // Reserved bits stay zero and unmapped reads return zero
   reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (output_divider_ctrl[15:10] == 6'h00) && !output_divider_ctrl[8]
      && reference_divider_ctrl[14:12] == 3'h0
      && memory_clock_output_ctrl[15:1] == 15'h0000)
      else $error("Reserved bits not zero");
   unmapped_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr != PWR_FB_CTRL_ADDR && IO_REQ.addr != REFDIV_CTRL_ADDR
       && IO_REQ.addr != TEST_INIT_ADDR && IO_REQ.addr != OUTDIV_CTRL_ADDR
       && IO_REQ.addr != MEMCLK_CTRL_ADDR) |=> IO_RDATA == 16'h0000)
      else $error("Unmapped read not zero");

   // Read data is the addressed register as it stood when the read was taken
   pwr_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr == PWR_FB_CTRL_ADDR)
      |=> IO_RDATA == $past(pll_power_feedback_ctrl))
      else $error("Power and feedback readback wrong");
   refdiv_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr == REFDIV_CTRL_ADDR)
      |=> IO_RDATA == $past(reference_divider_ctrl))
      else $error("Reference divider readback wrong");
   test_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr == TEST_INIT_ADDR)
      |=> IO_RDATA == $past(pll_test_init_word))
      else $error("Test word readback wrong");
   outdiv_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr == OUTDIV_CTRL_ADDR)
      |=> IO_RDATA == $past(output_divider_ctrl))
      else $error("Output divider readback wrong");
   memclk_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (IO_REQ.rd && IO_REQ.addr == MEMCLK_CTRL_ADDR)
      |=> IO_RDATA == $past(memory_clock_output_ctrl))
      else $error("Memory clock register readback wrong");

endmodule // clkgen_regs

// ### shared/clkgen_regs_pkg.sv
// Purpose: Constants and types for the clock generator control register block
// Assumes: 16-bit word-addressed I/O space, one system clock
// Notes:   Offsets are word addresses; registers are 16 bits wide
package clkgen_regs_pkg;

   // ==========================================================
   // Register word addresses
   localparam logic [15:0] MEMCLK_CTRL_ADDR  = 16'h1c1e;
   localparam logic [15:0] PWR_FB_CTRL_ADDR  = 16'h1c20;
   localparam logic [15:0] REFDIV_CTRL_ADDR  = 16'h1c21;
   localparam logic [15:0] TEST_INIT_ADDR    = 16'h1c22;
   localparam logic [15:0] OUTDIV_CTRL_ADDR  = 16'h1c23;

   // ==========================================================
   // Field positions and widths
   localparam int NORMAL_OP_BIT   = 15;
   localparam int PWRDN_BIT       = 12;
   localparam int RATIO12_W       = 12;
   localparam int REFBYP_BIT      = 15;
   localparam int OUTDIV_EN_BIT   = 9;
   localparam int OUTPUT_DIVIDER_RATIO_W       = 8;
   localparam int MEMCLK_EN_BIT   = 0;

   // Writable bit masks, reserved read-only bits excluded
   localparam logic [15:0] PWR_FB_MASK  = 16'hffff;
   localparam logic [15:0] REFDIV_MASK  = 16'h8fff;
   localparam logic [15:0] OUTDIV_MASK  = 16'h02ff;
   localparam logic [15:0] MEMCLK_MASK  = 16'h0001;

   // ==========================================================
   // Reset values
   localparam logic [15:0] PWR_FB_RESET    = 16'h1000;
   localparam logic [15:0] REFDIV_RESET    = 16'h0000;
   localparam logic [15:0] TEST_INIT_RESET = 16'h0806;
   localparam logic [15:0] OUTDIV_RESET    = 16'h0000;
   localparam logic [15:0] MEMCLK_RESET    = 16'h0000;

   // Ratio offsets
   localparam logic [12:0] MULT_OFFSET   = 13'h0004;
   localparam logic [12:0] REFDIV_OFFSET = 13'h0004;
   localparam logic [8:0]  ODIV_OFFSET   = 9'h001;

   // ==========================================================
   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } io_req_t;

   // Clock source modes
   typedef enum logic {
      MODE_BYPASS,
      MODE_PLL
   } clk_mode_t;

   // Mask a write onto the writable bits only
   function automatic logic [15:0] masked_write(input logic [15:0] mask,
                                                input logic [15:0] data);
      return data & mask;
   endfunction

endpackage

// ### dv/clkgen_regs_tb.sv
// Purpose: Self-checking bench for the clock generator control registers
// Assumes: Bench drives the I/O strobes, mode request and rate select directly
// Notes:   A word-array model of the five registers is compared after every random-pass write; all-ones writes read back only the register written
`timescale 1ns/1ps
module clkgen_regs_tb;
   import clkgen_regs_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic        CLK_SYS, RESET, PLL_MODE_REQ, HALF_RATE;
   io_req_t     IO_REQ;
   logic [15:0] IO_RDATA, PLL_TEST_WORD;
   logic [12:0] PLL_MULTIPLIER, REF_DIVIDE_VALUE;
   logic [8:0]  OUTPUT_DIVIDE_VALUE;
   logic        PLL_MODE, PLL_POWER_DOWN, PLL_NORMAL_OP, REF_DIVIDER_BYPASS;
   logic        OUTPUT_DIVIDER_ENABLE, MEMORY_CLOCK_PIN;
   int          bad_count, cmp_count, cyc;
   logic [15:0] q, wd;
   int          k;
   // Lock wait scaled down; the full software delay would outlast the run
   localparam int LOCK_WAIT = 16;
   logic [15:0] adr[5] = '{MEMCLK_CTRL_ADDR, PWR_FB_CTRL_ADDR, REFDIV_CTRL_ADDR,
                           TEST_INIT_ADDR, OUTDIV_CTRL_ADDR};
   logic [15:0] msk[5] = '{MEMCLK_MASK, PWR_FB_MASK, REFDIV_MASK, 16'hffff, OUTDIV_MASK};
   logic [15:0] mdl[5];
   clkgen_regs clkgen_regs_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .IO_REQ(IO_REQ),
      .IO_RDATA(IO_RDATA), .PLL_MODE_REQ(PLL_MODE_REQ), .HALF_RATE(HALF_RATE),
      .PLL_MODE(PLL_MODE), .PLL_POWER_DOWN(PLL_POWER_DOWN), .PLL_NORMAL_OP(PLL_NORMAL_OP),
      .PLL_MULTIPLIER(PLL_MULTIPLIER), .REF_DIVIDER_BYPASS(REF_DIVIDER_BYPASS),
      .REF_DIVIDE_VALUE(REF_DIVIDE_VALUE), .PLL_TEST_WORD(PLL_TEST_WORD),
      .OUTPUT_DIVIDER_ENABLE(OUTPUT_DIVIDER_ENABLE),
      .OUTPUT_DIVIDE_VALUE(OUTPUT_DIVIDE_VALUE), .MEMORY_CLOCK_PIN(MEMORY_CLOCK_PIN));
   // ==========================================================
   // Clock, 8 ns period, and a cycle ceiling against hangs
   initial begin
      CLK_SYS = 0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Shared compare, bus access and model tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One strobe cycle, answer sampled after the taking edge has landed
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge CLK_SYS);
      IO_REQ <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge CLK_SYS);
      IO_REQ <= '0;
      #1 q = IO_RDATA;
      for (int i = 0; i < 5; i++) if (w && a == adr[i]) mdl[i] = d & msk[i];
   endtask
   task automatic rdchk(input int i);
      acc(0, adr[i], 16'h0000);
      chk(q, mdl[i], "readback");
   endtask
   task automatic outs();
      chk(PLL_POWER_DOWN, mdl[1][12], "power down");
      chk(PLL_NORMAL_OP, mdl[1][15], "normal op bit");
      chk(PLL_MULTIPLIER, mdl[1][11:0] + 16'h0004, "multiplier");
      chk(REF_DIVIDER_BYPASS, mdl[2][15], "ref bypass");
      chk(REF_DIVIDE_VALUE, mdl[2][11:0] + 16'h0004, "ref divide");
      chk(PLL_TEST_WORD, mdl[3], "test word");
      chk(OUTPUT_DIVIDER_ENABLE, mdl[4][9], "out div enable");
      chk(OUTPUT_DIVIDE_VALUE, mdl[4][7:0] + 16'h0001, "out divide");
   endtask
   // Counts memory clock transitions over eight settled samples
   task automatic mclk(input int exp);
      logic p;
      int   n;
      n = 0;
      repeat (2) @(posedge CLK_SYS);
      #1 p = MEMORY_CLOCK_PIN;
      repeat (8) begin
         @(posedge CLK_SYS);
         #1 if (MEMORY_CLOCK_PIN !== p) n++;
         p = MEMORY_CLOCK_PIN;
      end
      chk(16'(n), 16'(exp), "memory clock toggles");
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      RESET = 1;
      IO_REQ = '0;
      PLL_MODE_REQ = 0;
      HALF_RATE = 0;
      bad_count = 0;
      cmp_count = 0;
      cyc = 0;
      mdl = '{16'h0000, 16'h1000, 16'h0000, 16'h0806, 16'h0000};
      void'($urandom(32'h4a80));
      repeat (6) @(posedge CLK_SYS);
      RESET <= 0;
      outs();
      for (int i = 0; i < 5; i++) rdchk(i);
      // Power-down still set: PLL mode request refused
      @(posedge CLK_SYS) PLL_MODE_REQ <= 1;
      repeat (3) @(posedge CLK_SYS);
      #1 chk(PLL_MODE, 1'b0, "pll mode refused");
      // Configure in bypass, power up, let the PLL lock, then select PLL mode
      @(posedge CLK_SYS) PLL_MODE_REQ <= 0;
      acc(1, TEST_INIT_ADDR, 16'h0806);
      acc(1, PWR_FB_CTRL_ADDR, 16'h8123);
      outs();
      repeat (LOCK_WAIT) @(posedge CLK_SYS);
      #1 chk(PLL_MODE, 1'b0, "bypass during lock");
      @(posedge CLK_SYS) PLL_MODE_REQ <= 1;
      repeat (2) @(posedge CLK_SYS);
      #1 chk(PLL_MODE, 1'b1, "pll mode entered");
      acc(1, PWR_FB_CTRL_ADDR, 16'h9123);
      #1 chk(PLL_MODE, 1'b1, "pll mode kept");
      @(posedge CLK_SYS) PLL_MODE_REQ <= 0;
      repeat (2) @(posedge CLK_SYS);
      #1 chk(PLL_MODE, 1'b0, "bypass again");
      // All ones (16'h9fff for the power register), then random words, into every register and one unmapped place
      for (int i = 0; i < 5; i++) begin
         acc(1, adr[i], (i == 1) ? 16'h9fff : 16'hffff);
         rdchk(i);
         outs();
      end
      repeat (30) begin
         k = $urandom % 5;
         wd = 16'($urandom);
         if (k == 1) wd = wd & 16'h9fff;
         acc(1, adr[k], wd);
         for (int i = 0; i < 5; i++) rdchk(i);
         outs();
      end
      acc(1, 16'h1c1f, 16'hffff);
      acc(0, 16'h1c1f, 16'h0000);
      chk(q, 16'h0000, "unmapped read");
      for (int i = 0; i < 5; i++) rdchk(i);
      // Memory clock: full rate, half rate, then off and low
      acc(1, MEMCLK_CTRL_ADDR, 16'h0001);
      mclk(8);
      @(posedge CLK_SYS) HALF_RATE <= 1;
      mclk(4);
      acc(1, MEMCLK_CTRL_ADDR, 16'h0000);
      mclk(0);
      chk(MEMORY_CLOCK_PIN, 1'b0, "memory clock low");
      report_and_stop();
   end
endmodule // clkgen_regs_tb
